// file: pkg/brs_pkg.sv
package brs_pkg;
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned SW_1M_HZ     = 1_000_000;
    localparam int unsigned SW_2M_HZ     = 2_000_000;
    localparam int unsigned SW_4M_HZ     = 4_000_000;
    localparam int unsigned PER_W        = 5;
    // Switching periods in core cycles, rounded down
    localparam logic [PER_W-1:0] PER_1M  = PER_W'(CLK_HZ / SW_1M_HZ);
    localparam logic [PER_W-1:0] PER_2M  = PER_W'(CLK_HZ / SW_2M_HZ);
    localparam logic [PER_W-1:0] PER_4M  = PER_W'(CLK_HZ / SW_4M_HZ);

    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned IDX_W        = 6;
    localparam int unsigned NREG         = 5;
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] PAIRED_NORMAL_SETPOINT  = 6'h20;
    localparam logic [IDX_W-1:0] PAIRED_STANDBY_SETPOINT = 6'h21;
    localparam logic [IDX_W-1:0] PAIRED_SLEEP_SETPOINT   = 6'h22;
    localparam logic [IDX_W-1:0] PAIRED_SWITCH_MODE      = 6'h23;
    localparam logic [IDX_W-1:0] PAIRED_TIMING_CONFIG    = 6'h24;
    localparam logic [IDX_W-1:0] SINGLE_NORMAL_SETPOINT  = 6'h2E;
    localparam logic [IDX_W-1:0] SINGLE_STANDBY_SETPOINT = 6'h2F;
    localparam logic [IDX_W-1:0] SINGLE_SLEEP_SETPOINT   = 6'h30;
    localparam logic [IDX_W-1:0] SINGLE_SWITCH_MODE      = 6'h31;
    localparam logic [IDX_W-1:0] SINGLE_TIMING_CONFIG    = 6'h32;

    localparam logic [2:0] SLOT_NORMAL   = 3'h0;
    localparam logic [2:0] SLOT_STANDBY  = 3'h1;
    localparam logic [2:0] SLOT_SLEEP    = 3'h2;
    localparam logic [2:0] SLOT_MODE     = 3'h3;
    localparam logic [2:0] SLOT_CONFIG   = 3'h4;

    localparam logic [7:0] RST_SETPOINT  = 8'h00;
    localparam logic [7:0] RST_MODE      = 8'h00;
    localparam logic [7:0] RST_CONFIG    = 8'h00;
    localparam logic [7:0] MASK_SETPOINT = 8'h3F;
    localparam logic [7:0] MASK_MODE     = 8'h2F;
    localparam logic [7:0] MASK_CONFIG   = 8'hFF;

    // Field positions
    localparam int unsigned MODE_SEL_LSB   = 0;
    localparam int unsigned MODE_SLEEP_BIT = 5;
    localparam int unsigned CONF_LIMIT_BIT = 0;
    localparam int unsigned CONF_FREQ_LSB  = 2;
    localparam int unsigned CONF_PHASE_LSB = 4;
    localparam int unsigned CONF_SCALE_LSB = 6;

    localparam int unsigned MV_W           = 11;
    localparam logic [MV_W-1:0] BASE_MV    = 11'h12C;
    localparam logic [MV_W-1:0] STEP_MV    = 11'h019;

    localparam logic [1:0] FREQ_1M       = 2'h0;
    localparam logic [1:0] FREQ_2M       = 2'h1;
    localparam logic [1:0] FREQ_4M       = 2'h2;

    typedef enum logic [1:0] {
        GRP_ALL_SINGLE,
        GRP_AB_SINGLE_C_INDEP,
        GRP_AB_DUAL_C_INDEP,
        GRP_RESERVED
    } brs_group_type;

    typedef enum logic [1:0] {
        OP_NORMAL,
        OP_STANDBY,
        OP_SLEEP,
        OP_SLEEP_ALT
    } brs_opstate_type;
endpackage : brs_pkg

// file: pkg/brs_cfg_if.sv
`timescale 1ns/1ps
interface brs_cfg_if;
    import brs_pkg::*;
    brs_group_type group;
    logic [1:0]    pair_freq;
    logic [1:0]    single_freq;
    logic [1:0]    single_phase;
    logic          pair_en;
    logic          single_en;
    logic          node_a;
    logic          node_b;
    logic          node_c;

    modport ctrl (
        output group, pair_freq, single_freq, single_phase,
        output pair_en, single_en,
        input  node_a, node_b, node_c
    );
    modport gen (
        input  group, pair_freq, single_freq, single_phase,
        input  pair_en, single_en,
        output node_a, node_b, node_c
    );
endinterface : brs_cfg_if

// file: core/brs_phase_gen.sv
`timescale 1ns/1ps
module brs_phase_gen
    import brs_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Timing settings and switching nodes
    brs_cfg_if.gen    cfg
);
    typedef struct packed {
        logic [PER_W-1:0] cnt_p;
        logic [PER_W-1:0] cnt_s;
        logic             a;
        logic             b;
        logic             c;
    } brs_gen_type;

    brs_gen_type st_r;
    brs_gen_type st_nxt;

    function automatic logic [PER_W-1:0] period(input logic [1:0] f);
        unique case (f)
            FREQ_1M: period = PER_1M;
            FREQ_2M: period = PER_2M;
            FREQ_4M: period = PER_4M;
            default: period = '0;
        endcase
    endfunction : period

    function automatic logic [PER_W-1:0] wrap_add(
        input logic [PER_W-1:0] c,
        input logic [PER_W-1:0] off,
        input logic [PER_W-1:0] per
    );
        logic [PER_W:0] s;
        s = {1'b0, c} + {1'b0, off};
        if (s >= {1'b0, per}) begin
            s = s - {1'b0, per};
        end
        wrap_add = s[PER_W-1:0];
    endfunction : wrap_add

    logic [PER_W-1:0] per_p;
    logic [PER_W-1:0] per_s;
    logic [PER_W-1:0] half_p;
    logic [PER_W-1:0] half_s;
    logic [PER_W+1:0] off_prod;
    logic [PER_W-1:0] off_s;
    logic             pa;
    logic             pb;
    logic             pc;

    always_comb begin
        st_nxt   = st_r;
        per_p    = period(cfg.pair_freq);
        per_s    = period(cfg.single_freq);
        half_p   = per_p >> 1;
        half_s   = per_s >> 1;
        off_prod = {2'b00, per_s} * {5'h00, cfg.single_phase};
        off_s    = off_prod[PER_W+1:2];
        // Counters beyond a newly chosen shorter period restart at zero
        st_nxt.cnt_p = (st_r.cnt_p + 5'h01 >= per_p) ? '0 : st_r.cnt_p + 5'h01;
        st_nxt.cnt_s = (st_r.cnt_s + 5'h01 >= per_s) ? '0 : st_r.cnt_s + 5'h01;
        pa = (per_p != '0) && (st_r.cnt_p < half_p);
        pb = (per_p != '0)
             && (wrap_add(st_r.cnt_p, half_p, per_p) < half_p);
        pc = (per_s != '0)
             && (wrap_add(st_r.cnt_s, off_s, per_s) < half_s);
        unique case (cfg.group)
            GRP_ALL_SINGLE: begin
                st_nxt.a = cfg.single_en && pc;
                st_nxt.b = cfg.single_en && pc;
                st_nxt.c = cfg.single_en && pc;
            end
            GRP_AB_SINGLE_C_INDEP: begin
                st_nxt.a = cfg.pair_en && pa;
                st_nxt.b = cfg.pair_en && pa;
                st_nxt.c = cfg.single_en && pc;
            end
            GRP_AB_DUAL_C_INDEP: begin
                st_nxt.a = cfg.pair_en && pa;
                st_nxt.b = cfg.pair_en && pb;
                st_nxt.c = cfg.single_en && pc;
            end
            GRP_RESERVED: begin
                st_nxt.a = 1'b0;
                st_nxt.b = 1'b0;
                st_nxt.c = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfg.node_a = st_r.a;
    assign cfg.node_b = st_r.b;
    assign cfg.node_c = st_r.c;
endmodule : brs_phase_gen

// file: core/brs_setpoint_regs.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - In dual-phase grouping, phase B runs half a period after phase A.
// - In dual-phase grouping, A and B take timing from the paired config.
// - In dual-phase grouping, phase C takes timing only from its config.
// - Outside all-single grouping, each output keeps its own set points, mode selection and enable.
// - A set-point code means 300 mV plus 25 mV per step, 1875 mV at most.
// - Each output applies the set point matching the operating state.
// - Paired registers: normal, standby, sleep, mode, config in a row.
// - Single registers: normal, standby, sleep, mode, config in a row.
// - Each config byte holds scaling speed, phase, frequency, limit.
// - The normal set point is a read/write code in bits 5:0, reset 0x00.
// - The standby set point is a read/write low code, reset 0x00.
// - A fixed 2-bit grouping field picks the grouping; 11 is reserved.
module brs_setpoint_regs
    import brs_pkg::*;
(
    // Clock and reset
    input  wire logic                   CORE_CLK,
    input  wire logic                   SRST,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]      AVS_ADDRESS,
    input  wire logic                   AVS_READ,
    input  wire logic                   AVS_WRITE,
    input  wire logic [3:0]             AVS_BYTEENABLE,
    input  wire logic [DATA_W-1:0]      AVS_WRITEDATA,
    output logic      [DATA_W-1:0]      AVS_READDATA,
    output logic                        AVS_WAITREQUEST,
    // Pins from outside the clock domain
    input  wire logic [1:0]             PHASE_GROUPING_SELECT,
    input  wire logic [1:0]             OPERATING_STATE,
    // Paired output controls
    output logic [5:0]                  PAIRED_SETPOINT_CODE,
    output logic [MV_W-1:0]             PAIRED_TARGET_MV,
    output logic [1:0]                  PAIRED_VOLTAGE_SCALING,
    output logic                        PAIRED_CURRENT_LIMIT_LEVEL,
    output logic                        PAIRED_ENABLE,
    // Single output controls
    output logic [5:0]                  SINGLE_SETPOINT_CODE,
    output logic [MV_W-1:0]             SINGLE_TARGET_MV,
    output logic [1:0]                  SINGLE_VOLTAGE_SCALING,
    output logic                        SINGLE_CURRENT_LIMIT_LEVEL,
    output logic                        SINGLE_ENABLE,
    // Switching nodes
    output logic                        PHASE_A_SWITCH_NODE,
    output logic                        PHASE_B_SWITCH_NODE,
    output logic                        PHASE_C_SWITCH_NODE
);
    import brs_pkg::*;

    typedef struct packed {
        logic                   waitreq;
        logic [DATA_W-1:0]      rdata;
        logic [NREG-1:0][7:0]   pr;
        logic [NREG-1:0][7:0]   sr;
        logic [1:0]             grp_s1;
        logic [1:0]             grp_s2;
        logic [1:0]             op_s1;
        logic [1:0]             op_s2;
        logic [5:0]             pcode;
        logic [5:0]             scode;
        logic [MV_W-1:0]        pmv;
        logic [MV_W-1:0]        smv;
        logic [1:0]             pdvs;
        logic [1:0]             sdvs;
        logic                   pilim;
        logic                   silim;
        logic                   pen;
        logic                   sen;
        logic [1:0]             pfreq;
        logic [1:0]             sfreq;
        logic [1:0]             sphase;
    } brs_top_type;

    typedef struct packed {
        logic       hit;
        logic       single;
        logic [2:0] slot;
    } brs_dec_type;

    brs_top_type st_r;
    brs_top_type st_nxt;

    brs_cfg_if cfg_if ();

    // Byte address to register slot
    function automatic brs_dec_type decode(input logic [ADDR_W-1:0] a);
        logic [IDX_W-1:0] idx;
        idx    = a[ADDR_W-1:2];
        decode = '0;
        if (a[1:0] == 2'h0) begin
            if (idx >= PAIRED_NORMAL_SETPOINT
                && idx <= PAIRED_TIMING_CONFIG) begin
                decode.hit  = 1'b1;
                decode.slot = 3'(idx - PAIRED_NORMAL_SETPOINT);
            end else if (idx >= SINGLE_NORMAL_SETPOINT
                && idx <= SINGLE_TIMING_CONFIG) begin
                decode.hit    = 1'b1;
                decode.single = 1'b1;
                decode.slot   = 3'(idx - SINGLE_NORMAL_SETPOINT);
            end
        end
    endfunction : decode

    // Implemented bits of each slot
    function automatic logic [7:0] slot_mask(input logic [2:0] s);
        unique case (s)
            SLOT_MODE:   slot_mask = MASK_MODE;
            SLOT_CONFIG: slot_mask = MASK_CONFIG;
            default:     slot_mask = MASK_SETPOINT;
        endcase
    endfunction : slot_mask

    function automatic logic [2:0] state_slot(input logic [1:0] op);
        unique case (brs_opstate_type'(op))
            OP_NORMAL:  state_slot = SLOT_NORMAL;
            OP_STANDBY: state_slot = SLOT_STANDBY;
            default:    state_slot = SLOT_SLEEP;
        endcase
    endfunction : state_slot

    function automatic logic [MV_W-1:0] code_to_mv(input logic [5:0] c);
        code_to_mv = BASE_MV + MV_W'({5'h00, c} * STEP_MV);
    endfunction : code_to_mv

    // On when the mode selector is nonzero, and in sleep only if kept on
    function automatic logic output_on(
        input logic [7:0] mode,
        input logic       sleeping
    );
        output_on = (mode[MODE_SEL_LSB +: 4] != 4'h0)
                    && !(sleeping && !mode[MODE_SLEEP_BIT]);
    endfunction : output_on

    brs_dec_type        dec;
    logic [7:0]         rd_byte;
    logic [7:0]         wr_byte;
    logic [2:0]         op_slot;
    logic               sleeping;
    logic [7:0]         pconf;
    logic [7:0]         sconf;
    brs_group_type      grp;

    always_comb begin
        st_nxt   = st_r;
        dec      = decode(AVS_ADDRESS);
        rd_byte  = dec.single ? st_r.sr[dec.slot] : st_r.pr[dec.slot];
        wr_byte  = AVS_WRITEDATA[7:0] & slot_mask(dec.slot);

        // One wait cycle, then waitrequest low for one cycle
        if (st_r.waitreq) begin
            if (AVS_READ || AVS_WRITE) begin
                st_nxt.waitreq = 1'b0;
                st_nxt.rdata   = '0;
                if (AVS_READ && dec.hit) begin
                    st_nxt.rdata[7:0] = rd_byte & slot_mask(dec.slot);
                end
            end
        end else begin
            st_nxt.waitreq = 1'b1;
            if (AVS_WRITE && dec.hit && AVS_BYTEENABLE[0]) begin
                if (dec.single) begin
                    st_nxt.sr[dec.slot] = wr_byte;
                end else begin
                    st_nxt.pr[dec.slot] = wr_byte;
                end
            end
        end

        st_nxt.grp_s1 = PHASE_GROUPING_SELECT;
        st_nxt.grp_s2 = st_r.grp_s1;
        st_nxt.op_s1  = OPERATING_STATE;
        st_nxt.op_s2  = st_r.op_s1;

        grp      = brs_group_type'(st_r.grp_s2);
        op_slot  = state_slot(st_r.op_s2);
        sleeping = (op_slot == SLOT_SLEEP);
        sconf    = st_r.sr[SLOT_CONFIG];
        // All-single grouping runs every phase from the single set
        pconf    = (grp == GRP_ALL_SINGLE) ? sconf : st_r.pr[SLOT_CONFIG];

        st_nxt.pcode = (grp == GRP_ALL_SINGLE)
                       ? st_r.sr[op_slot][5:0]
                       : st_r.pr[op_slot][5:0];
        st_nxt.scode = st_r.sr[op_slot][5:0];
        st_nxt.pmv   = code_to_mv(st_nxt.pcode);
        st_nxt.smv   = code_to_mv(st_nxt.scode);

        st_nxt.pdvs   = pconf[CONF_SCALE_LSB +: 2];
        st_nxt.sdvs   = sconf[CONF_SCALE_LSB +: 2];
        st_nxt.pilim  = pconf[CONF_LIMIT_BIT];
        st_nxt.silim  = sconf[CONF_LIMIT_BIT];
        st_nxt.pfreq  = pconf[CONF_FREQ_LSB +: 2];
        st_nxt.sfreq  = sconf[CONF_FREQ_LSB +: 2];
        st_nxt.sphase = sconf[CONF_PHASE_LSB +: 2];

        st_nxt.pen = (grp != GRP_RESERVED)
                     && output_on((grp == GRP_ALL_SINGLE)
                                  ? st_r.sr[SLOT_MODE]
                                  : st_r.pr[SLOT_MODE], sleeping);
        st_nxt.sen = (grp != GRP_RESERVED)
                     && output_on(st_r.sr[SLOT_MODE], sleeping);
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            st_r          <= '0;
            st_r.waitreq  <= 1'b1;
            st_r.pr[SLOT_NORMAL]  <= RST_SETPOINT;
            st_r.pr[SLOT_STANDBY] <= RST_SETPOINT;
            st_r.pr[SLOT_SLEEP]   <= RST_SETPOINT;
            st_r.pr[SLOT_MODE]    <= RST_MODE;
            st_r.pr[SLOT_CONFIG]  <= RST_CONFIG;
            st_r.sr[SLOT_NORMAL]  <= RST_SETPOINT;
            st_r.sr[SLOT_STANDBY] <= RST_SETPOINT;
            st_r.sr[SLOT_SLEEP]   <= RST_SETPOINT;
            st_r.sr[SLOT_MODE]    <= RST_MODE;
            st_r.sr[SLOT_CONFIG]  <= RST_CONFIG;
            st_r.pmv      <= BASE_MV;
            st_r.smv      <= BASE_MV;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfg_if.group        = brs_group_type'(st_r.grp_s2);
    assign cfg_if.pair_freq    = st_r.pfreq;
    assign cfg_if.single_freq  = st_r.sfreq;
    assign cfg_if.single_phase = st_r.sphase;
    assign cfg_if.pair_en      = st_r.pen;
    assign cfg_if.single_en    = st_r.sen;

    brs_phase_gen u_phase_gen (
        .clk  (CORE_CLK),
        .srst (SRST),
        .cfg  (cfg_if.gen)
    );

    assign AVS_WAITREQUEST            = st_r.waitreq;
    assign AVS_READDATA               = st_r.rdata;
    assign PAIRED_SETPOINT_CODE       = st_r.pcode;
    assign PAIRED_TARGET_MV           = st_r.pmv;
    assign PAIRED_VOLTAGE_SCALING     = st_r.pdvs;
    assign PAIRED_CURRENT_LIMIT_LEVEL = st_r.pilim;
    assign PAIRED_ENABLE              = st_r.pen;
    assign SINGLE_SETPOINT_CODE       = st_r.scode;
    assign SINGLE_TARGET_MV           = st_r.smv;
    assign SINGLE_VOLTAGE_SCALING     = st_r.sdvs;
    assign SINGLE_CURRENT_LIMIT_LEVEL = st_r.silim;
    assign SINGLE_ENABLE              = st_r.sen;
    assign PHASE_A_SWITCH_NODE        = cfg_if.node_a;
    assign PHASE_B_SWITCH_NODE        = cfg_if.node_b;
    assign PHASE_C_SWITCH_NODE        = cfg_if.node_c;
endmodule : brs_setpoint_regs

// file: test/brs_setpoint_regs_chk.sv
`timescale 1ns/1ps
module brs_setpoint_regs_chk
    import brs_pkg::*;
(
    // Clock and reset
    input wire logic              CORE_CLK,
    input wire logic              SRST,
    // Register bus
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input wire logic              AVS_READ,
    input wire logic              AVS_WRITE,
    input wire logic [DATA_W-1:0] AVS_READDATA,
    input wire logic              AVS_WAITREQUEST,
    // Pins and outputs
    input wire logic [1:0]        PHASE_GROUPING_SELECT,
    input wire logic [5:0]        PAIRED_SETPOINT_CODE,
    input wire logic [MV_W-1:0]   PAIRED_TARGET_MV,
    input wire logic              PAIRED_ENABLE,
    input wire logic [5:0]        SINGLE_SETPOINT_CODE,
    input wire logic [MV_W-1:0]   SINGLE_TARGET_MV,
    input wire logic              SINGLE_ENABLE,
    input wire logic              PHASE_A_SWITCH_NODE,
    input wire logic              PHASE_B_SWITCH_NODE,
    input wire logic              PHASE_C_SWITCH_NODE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    // Cycles since the grouping pin last moved, saturating
    logic [1:0] grp_r;
    logic [2:0] cnt_r;
    wire logic  steady = (cnt_r == 3'h7);

    always_ff @(posedge CORE_CLK) begin
        grp_r <= PHASE_GROUPING_SELECT;
        if (SRST || grp_r != PHASE_GROUPING_SELECT) begin
            cnt_r <= 3'h0;
        end else if (cnt_r != 3'h7) begin
            cnt_r <= cnt_r + 3'h1;
        end
    end

    pair_mv_decode_a: assert property (
        PAIRED_TARGET_MV == BASE_MV + STEP_MV * MV_W'(PAIRED_SETPOINT_CODE))
        else $error("paired target voltage off its code");
    single_mv_decode_a: assert property (
        SINGLE_TARGET_MV == BASE_MV + STEP_MV * MV_W'(SINGLE_SETPOINT_CODE))
        else $error("single target voltage off its code");
    reset_state_a: assert property (
        $fell(SRST) |-> AVS_WAITREQUEST && !PAIRED_ENABLE && !SINGLE_ENABLE
            && {PAIRED_SETPOINT_CODE, SINGLE_SETPOINT_CODE} == 12'h000)
        else $error("outputs not at reset state");
    bus_answer_a: assert property (
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
            |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("request not answered in one cycle");
    read_zero_a: assert property (
        AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000
            && (AVS_ADDRESS[1:0] == 2'h0 || AVS_READDATA == 32'h00000000))
        else $error("read data carries bits outside the register");
    dual_no_overlap_a: assert property (
        steady && grp_r == 2'h2
            |-> !(PHASE_A_SWITCH_NODE && PHASE_B_SWITCH_NODE))
        else $error("paired nodes high together in dual phase");
    pair_same_a: assert property (
        steady && grp_r == 2'h1 |-> PHASE_A_SWITCH_NODE == PHASE_B_SWITCH_NODE)
        else $error("paired nodes differ in single phase");
    reserved_off_a: assert property (
        steady && grp_r == 2'h3 |-> !PAIRED_ENABLE && !SINGLE_ENABLE
            && !PHASE_A_SWITCH_NODE && !PHASE_B_SWITCH_NODE
            && !PHASE_C_SWITCH_NODE)
        else $error("reserved grouping left something running");
endmodule : brs_setpoint_regs_chk

// file: test/brs_host_model.sv
`timescale 1ns/1ps
module brs_host_model
    import brs_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Avalon-MM master side
    output logic [ADDR_W-1:0]      address,
    output logic                   read,
    output logic                   write,
    output logic [3:0]             byteenable,
    output logic [DATA_W-1:0]      writedata,
    input  wire logic [DATA_W-1:0] readdata,
    input  wire logic              waitrequest
);
    initial begin
        {address, read, write, byteenable, writedata} = '0;
    end

    // Request held until waitrequest is sampled low, for at most 16 cycles
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
            input logic [3:0] be, input logic [DATA_W-1:0] d,
            output logic [DATA_W-1:0] q, output bit ok);
        int n;
        ok = 1'b0;
        q = '0;
        @(posedge clk);
        address <= a;
        byteenable <= be;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) begin
                ok = 1'b1;
                q = readdata;
            end
        end
        read <= 1'b0;
        write <= 1'b0;
        // Released data shows no stale value
        writedata <= ~d;
    endtask : xfer
endmodule : brs_host_model

// file: test/brs_setpoint_regs_tb.sv
`timescale 1ns/1ps
module brs_setpoint_regs_tb;
    import brs_pkg::*;
    logic              CORE_CLK = 1'b0;
    logic              SRST = 1'b1;
    logic [1:0]        grp = 2'h0;
    logic [1:0]        opst = 2'h0;
    logic [ADDR_W-1:0] adr;
    logic              rd_s, wr_s, wait_s;
    logic [3:0]        be;
    logic [DATA_W-1:0] wdat, rdat;
    logic [5:0]        p_code, s_code;
    logic [MV_W-1:0]   p_mv, s_mv;
    logic [1:0]        p_vs, s_vs;
    logic              p_il, s_il, p_en, s_en, nd_a, nd_b, nd_c;
    logic [7:0]        exp_r [10];
    logic [5:0]        pc [3] = '{6'h0D, 6'h28, 6'h3F};
    logic [5:0]        sc [3] = '{6'h14, 6'h21, 6'h32};
    logic [49:0]       ha, hb, hc;
    int                num_errors = 0;
    int                total_checks = 0;

    always #20 CORE_CLK = ~CORE_CLK;

    brs_host_model i_brs_host_model (.clk(CORE_CLK), .address(adr),
        .read(rd_s), .write(wr_s), .byteenable(be), .writedata(wdat),
        .readdata(rdat), .waitrequest(wait_s));
    brs_setpoint_regs i_brs_setpoint_regs (.CORE_CLK, .SRST,
        .AVS_ADDRESS(adr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
        .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wait_s), .PHASE_GROUPING_SELECT(grp),
        .OPERATING_STATE(opst), .PAIRED_SETPOINT_CODE(p_code),
        .PAIRED_TARGET_MV(p_mv), .PAIRED_VOLTAGE_SCALING(p_vs),
        .PAIRED_CURRENT_LIMIT_LEVEL(p_il), .PAIRED_ENABLE(p_en),
        .SINGLE_SETPOINT_CODE(s_code), .SINGLE_TARGET_MV(s_mv),
        .SINGLE_VOLTAGE_SCALING(s_vs), .SINGLE_CURRENT_LIMIT_LEVEL(s_il),
        .SINGLE_ENABLE(s_en), .PHASE_A_SWITCH_NODE(nd_a),
        .PHASE_B_SWITCH_NODE(nd_b), .PHASE_C_SWITCH_NODE(nd_c));

    function automatic logic [7:0] addr_of(int i);
        return {(i < 5) ? 6'h20 + 6'(i) : 6'h2E + 6'(i - 5), 2'b00};
    endfunction : addr_of
    function automatic logic [7:0] mask_of(int i);
        return (i % 5 < 3) ? 8'h3F : (i % 5 == 3) ? 8'h2F : 8'hFF;
    endfunction : mask_of
    function automatic logic [MV_W-1:0] mv_of(logic [5:0] c);
        return 11'h12C + 11'h019 * {5'h00, c};
    endfunction : mv_of

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [7:0] d, input logic [3:0] en,
            output logic [31:0] q);
        bit ok;
        repeat ($urandom % 3) @(posedge CORE_CLK);
        i_brs_host_model.xfer(wr, a, en, {24'h000000, d}, q, ok);
        if (!ok) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : bus
    task automatic wreg(input logic [7:0] a, input logic [7:0] d,
            input logic [3:0] en);
        logic [31:0] q;
        bus(1'b1, a, d, en, q);
    endtask : wreg
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, 4'h1, q);
        check(q, {24'h000000, e});
    endtask : rchk
    initial begin : watchdog
        repeat (20000) @(posedge CORE_CLK);
        num_errors++;
        tally_and_finish();
    end

    initial begin : main
        logic [7:0] d;
        int i;
        int n;
        void'($urandom(56));
        repeat (20) @(posedge CORE_CLK);
        SRST <= 1'b0;
        for (i = 0; i < 10; i++) rchk(addr_of(i), 8'h00);
        $display("test reset_values done");
        for (i = 0; i < 10; i++) begin
            wreg(addr_of(i), 8'hFF, 4'h1);
            exp_r[i] = mask_of(i);
        end
        for (i = 0; i < 10; i++) rchk(addr_of(i), exp_r[i]);
        // Misaligned, unselected byte and unmapped writes all refused
        wreg(8'h81, 8'h15, 4'h1);
        wreg(8'h80, 8'h15, 4'h0);
        wreg(8'hB4, 8'h15, 4'h1);
        wreg(8'hCC, 8'h15, 4'h1);
        rchk(8'h80, 8'h3F);
        rchk(8'h81, 8'h00);
        rchk(8'hB4, 8'h00);
        rchk(8'hCC, 8'h00);
        $display("test map_and_refusal done");
        for (i = 0; i < 40; i++) begin
            n = $urandom % 10;
            d = 8'($urandom);
            if (n % 5 < 3) d[5:0] = 6'(13 + $urandom % 51);
            wreg(addr_of(n), d, 4'h1);
            exp_r[n] = d & mask_of(n);
            n = $urandom % 10;
            rchk(addr_of(n), exp_r[n]);
        end
        $display("test random_access done");
        wreg(addr_of(4), 8'h89, 4'h1);
        wreg(addr_of(9), 8'h40, 4'h1);
        wreg(addr_of(3), 8'h21, 4'h1);
        wreg(addr_of(8), 8'h01, 4'h1);
        for (i = 0; i < 3; i++) begin
            wreg(addr_of(i), {2'b11, pc[i]}, 4'h1);
            wreg(addr_of(i + 5), {2'b11, sc[i]}, 4'h1);
        end
        grp <= 2'h2;
        for (i = 0; i < 4; i++) begin
            opst <= 2'(i);
            repeat (6) @(posedge CORE_CLK);
            n = (i > 2) ? 2 : i;
            check(p_code, pc[n]);
            check(s_code, sc[n]);
            check(p_mv, mv_of(pc[n]));
            check(s_mv, mv_of(sc[n]));
            check(p_en, 1'b1);
            check(s_en, i < 2);
        end
        check({p_vs, p_il, s_vs, s_il}, 6'h2A);
        $display("test setpoints_and_states done");
        opst <= 2'h0;
        repeat (8) @(posedge CORE_CLK);
        for (i = 0; i < 50; i++) begin
            @(posedge CORE_CLK);
            ha[i] = nd_a;
            hb[i] = nd_b;
            hc[i] = nd_c;
        end
        for (i = 3; i < 50; i++) check(hb[i], ha[i - 3]);
        check($countones(ha[47:0]), 24);
        check($countones(hc), 24);
        $display("test dual_phase done");
        for (i = 1; i < 4; i += 2) begin
            grp <= 2'(i);
            repeat (12) @(posedge CORE_CLK);
        end
        check({p_en, s_en, nd_a, nd_b, nd_c}, 5'h00);
        grp <= 2'h0;
        repeat (12) @(posedge CORE_CLK);
        check({p_code, nd_a, nd_b}, {sc[0], nd_c, nd_c});
        $display("test grouping done");
        tally_and_finish();
    end
endmodule : brs_setpoint_regs_tb

bind brs_setpoint_regs brs_setpoint_regs_chk i_brs_setpoint_regs_chk (
    .CORE_CLK, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
    .AVS_WAITREQUEST, .PHASE_GROUPING_SELECT, .PAIRED_SETPOINT_CODE,
    .PAIRED_TARGET_MV, .PAIRED_ENABLE, .SINGLE_SETPOINT_CODE,
    .SINGLE_TARGET_MV, .SINGLE_ENABLE, .PHASE_A_SWITCH_NODE,
    .PHASE_B_SWITCH_NODE, .PHASE_C_SWITCH_NODE);
